// ### verilog/trap_flag_vector_unit.sv
// trap flag, trap vector and clock fallback logic with its register port
//
// What this block does
// - dma controller error trap vector sits at 0x00000e in the primary table.
// - alternate table places that vector at boot segment limit plus 0x00000e.
// - bit 5 of interrupt_control_one reads 1 once a dma trap occurred.
// - pll loss of lock may raise soft error trap at power-up on fast rc.
// - software clears bit 0 of interrupt_control_three; pll keeps running meanwhile.
// - pll regains lock by itself within 50 microseconds after losing it.
// - with rc select 0 and primary clock missing or failed, use fast rc.
`timescale 1ns/1ps
`default_nettype none
module trap_flag_vector_unit #(
  parameter int RELOCK_COUNT = trap_flag_vector_pkg::RELOCK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // trap events and vector request from the core
  input wire logic DMA_ERROR,
  input wire logic ALT_TABLE,
  output logic [23:0] DMA_VECTOR_ADDR,
  output logic SOFT_TRAP,
  // pll and oscillator status pins
  input wire logic PLL_LOCK_LOST,
  input wire logic PRIMARY_OSC_OK,
  output logic PLL_LOCKED_OUT,
  output logic PLL_RUN,
  output logic USE_FAST_RC,
  // interrupt
  output logic IRQ
);
  trap_flag_vector_pkg::reg_req_t req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  function automatic logic hit_wr(input trap_flag_vector_pkg::reg_req_t r, input logic [3:0] a);
    hit_wr = r.wr && (r.addr == a);
  endfunction

  // pin synchronisers: change counts once stages two and three agree
  logic [2:0] lost_sync_reg;
  logic [2:0] posc_sync_reg;
  logic lost_reg;
  logic posc_ok_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      lost_sync_reg <= 3'h0;
      posc_sync_reg <= 3'h0;
      lost_reg <= 1'b0;
      posc_ok_reg <= 1'b0;
    end
    else
    begin
      lost_sync_reg <= {lost_sync_reg[1:0], PLL_LOCK_LOST};
      posc_sync_reg <= {posc_sync_reg[1:0], PRIMARY_OSC_OK};
      if (lost_sync_reg[1] == lost_sync_reg[2])
        lost_reg <= lost_sync_reg[2];
      if (posc_sync_reg[1] == posc_sync_reg[2])
        posc_ok_reg <= posc_sync_reg[2];
    end
  end

  // configuration registers
  logic rc_select_reg;
  logic [12:0] bsl_reg;
  logic [2:0] mask_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      rc_select_reg <= 1'b0;
      bsl_reg <= trap_flag_vector_pkg::BOOT_SEGMENT_LIMIT_RESET;
      mask_reg <= trap_flag_vector_pkg::IRQ_MASK_RESET;
    end
    else
    begin
      if (hit_wr(req, trap_flag_vector_pkg::ADDR_CLOCK_CONTROL))
        rc_select_reg <= req.wdata[trap_flag_vector_pkg::RC_SELECT_BIT];
      if (hit_wr(req, trap_flag_vector_pkg::ADDR_BOOT_SEGMENT_LIMIT))
        bsl_reg <= req.wdata[12:0];
      if (hit_wr(req, trap_flag_vector_pkg::ADDR_IRQ_MASK))
        mask_reg <= req.wdata[2:0];
    end
  end

  // clock source selection
  trap_flag_vector_pkg::clock_source_t src_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      src_reg <= trap_flag_vector_pkg::SRC_FAST_RC;
    else if (!rc_select_reg && !posc_ok_reg)
      src_reg <= trap_flag_vector_pkg::SRC_FAST_RC;
    else
      src_reg <= trap_flag_vector_pkg::SRC_PRIMARY;
  end
  logic on_fast_rc;
  assign on_fast_rc = (src_reg == trap_flag_vector_pkg::SRC_FAST_RC);

  // power-up window: loss of lock only traps until the first lock is reached
  trap_flag_vector_pkg::pll_state_t pll_state_reg;
  logic powerup_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      powerup_reg <= 1'b1;
    else if (pll_state_reg == trap_flag_vector_pkg::PLL_LOCKED && !lost_reg)
      powerup_reg <= 1'b0;
  end

  // pll lock tracker with automatic relock
  logic [15:0] relock_cnt_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      pll_state_reg <= trap_flag_vector_pkg::PLL_OFF;
      relock_cnt_reg <= 16'h0000;
    end
    else
    begin
      unique case (pll_state_reg)
        trap_flag_vector_pkg::PLL_OFF:
        begin
          pll_state_reg <= trap_flag_vector_pkg::PLL_RELOCKING;
          relock_cnt_reg <= 16'h0000;
        end
        trap_flag_vector_pkg::PLL_LOCKED:
        begin
          if (lost_reg)
          begin
            pll_state_reg <= trap_flag_vector_pkg::PLL_RELOCKING;
            relock_cnt_reg <= 16'h0000;
          end
        end
        trap_flag_vector_pkg::PLL_RELOCKING:
        begin
          // relock bounded by the count regardless of software
          if (relock_cnt_reg >= 16'(RELOCK_COUNT - 1))
            pll_state_reg <= trap_flag_vector_pkg::PLL_LOCKED;
          else
            relock_cnt_reg <= relock_cnt_reg + 16'h0001;
        end
      endcase
    end
  end

  // trap events
  logic dma_event;
  logic pll_event;
  logic lost_seen_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      lost_seen_reg <= 1'b0;
    else
      lost_seen_reg <= lost_reg;
  end
  assign dma_event = DMA_ERROR;
  assign pll_event = lost_reg && !lost_seen_reg && powerup_reg && on_fast_rc;

  // sticky trap flags: set wins over software clear
  logic dma_flag_reg;
  logic pll_flag_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      dma_flag_reg <= 1'b0;
    else if (dma_event)
      dma_flag_reg <= 1'b1;
    else if (hit_wr(req, trap_flag_vector_pkg::ADDR_INTERRUPT_CONTROL_ONE)
             && !req.wdata[trap_flag_vector_pkg::DMA_TRAP_FLAG_BIT])
      dma_flag_reg <= 1'b0;
  end
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      pll_flag_reg <= 1'b0;
    else if (pll_event)
      pll_flag_reg <= 1'b1;
    else if (hit_wr(req, trap_flag_vector_pkg::ADDR_INTERRUPT_CONTROL_THREE)
             && !req.wdata[trap_flag_vector_pkg::PLL_TRAP_FLAG_BIT])
      pll_flag_reg <= 1'b0;
  end

  // interrupt status, write one to clear, set wins
  logic [2:0] irq_status_reg;
  logic [2:0] irq_set;
  logic fallback_event;
  logic src_prev_reg;
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      src_prev_reg <= 1'b1;
    else
      src_prev_reg <= on_fast_rc;
  end
  assign fallback_event = on_fast_rc && !src_prev_reg;
  always_comb
  begin
    irq_set = 3'h0;
    irq_set[trap_flag_vector_pkg::IRQ_DMA_BIT] = dma_event;
    irq_set[trap_flag_vector_pkg::IRQ_PLL_BIT] = pll_event;
    irq_set[trap_flag_vector_pkg::IRQ_FALLBACK_BIT] = fallback_event;
  end
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      irq_status_reg <= 3'h0;
    else if (hit_wr(req, trap_flag_vector_pkg::ADDR_IRQ_STATUS))
      irq_status_reg <= (irq_status_reg & ~req.wdata[2:0]) | irq_set;
    else
      irq_status_reg <= irq_status_reg | irq_set;
  end

  // outputs, all registered
  logic [23:0] vector_next;
  always_comb
  begin
    if (ALT_TABLE)
      vector_next = {11'h000, bsl_reg} + trap_flag_vector_pkg::DMA_TRAP_VECTOR_OFFSET;
    else
      vector_next = trap_flag_vector_pkg::PRIMARY_TABLE_BASE
                    + trap_flag_vector_pkg::DMA_TRAP_VECTOR_OFFSET;
  end
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      DMA_VECTOR_ADDR <= trap_flag_vector_pkg::DMA_TRAP_VECTOR_OFFSET;
      SOFT_TRAP <= 1'b0;
      PLL_LOCKED_OUT <= 1'b0;
      PLL_RUN <= 1'b0;
      USE_FAST_RC <= 1'b1;
      IRQ <= 1'b0;
    end
    else
    begin
      DMA_VECTOR_ADDR <= vector_next;
      SOFT_TRAP <= pll_flag_reg;
      PLL_LOCKED_OUT <= (pll_state_reg == trap_flag_vector_pkg::PLL_LOCKED) && !lost_reg;
      PLL_RUN <= 1'b1;
      USE_FAST_RC <= on_fast_rc;
      IRQ <= |(irq_status_reg & mask_reg);
    end
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      RDATA <= 16'h0000;
    else if (req.rd)
    begin
      unique case (req.addr)
        trap_flag_vector_pkg::ADDR_INTERRUPT_CONTROL_ONE:
          RDATA <= trap_flag_vector_pkg::INTERRUPT_CONTROL_ONE_RESET
                   | (16'(dma_flag_reg) << trap_flag_vector_pkg::DMA_TRAP_FLAG_BIT);
        trap_flag_vector_pkg::ADDR_INTERRUPT_CONTROL_THREE:
          RDATA <= trap_flag_vector_pkg::INTERRUPT_CONTROL_THREE_RESET
                   | (16'(pll_flag_reg) << trap_flag_vector_pkg::PLL_TRAP_FLAG_BIT);
        trap_flag_vector_pkg::ADDR_CLOCK_CONTROL:
          RDATA <= {15'h0000, rc_select_reg};
        trap_flag_vector_pkg::ADDR_BOOT_SEGMENT_LIMIT:
          RDATA <= {3'h0, bsl_reg};
        trap_flag_vector_pkg::ADDR_IRQ_STATUS:
          RDATA <= {13'h0000, irq_status_reg};
        trap_flag_vector_pkg::ADDR_IRQ_MASK:
          RDATA <= {13'h0000, mask_reg};
        trap_flag_vector_pkg::ADDR_CLOCK_STATUS:
          RDATA <= {13'h0000, on_fast_rc, powerup_reg,
                    pll_state_reg == trap_flag_vector_pkg::PLL_LOCKED};
        default:
          RDATA <= 16'h0000;
      endcase
    end
    else
      RDATA <= 16'h0000;
  end
endmodule
`default_nettype wire

// ### verilog/trap_flag_vector_pkg.sv
// package: register map, vector offsets, timing and carrier types for the trap unit
package trap_flag_vector_pkg;
  // register word addresses on the plain register port
  localparam logic [3:0] ADDR_INTERRUPT_CONTROL_ONE = 4'h0;
  localparam logic [3:0] ADDR_INTERRUPT_CONTROL_THREE = 4'h1;
  localparam logic [3:0] ADDR_CLOCK_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_BOOT_SEGMENT_LIMIT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_CLOCK_STATUS = 4'h6;
  // field positions
  localparam int DMA_TRAP_FLAG_BIT = 5;
  localparam int PLL_TRAP_FLAG_BIT = 0;
  localparam int RC_SELECT_BIT = 0;
  localparam int IRQ_DMA_BIT = 0;
  localparam int IRQ_PLL_BIT = 1;
  localparam int IRQ_FALLBACK_BIT = 2;
  localparam int BSL_WIDTH = 13;
  // vector offsets
  localparam logic [23:0] DMA_TRAP_VECTOR_OFFSET = 24'h00000e;
  localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000000;
  // reset values
  localparam logic [15:0] INTERRUPT_CONTROL_ONE_RESET = 16'h0000;
  localparam logic [15:0] INTERRUPT_CONTROL_THREE_RESET = 16'h0000;
  localparam logic [12:0] BOOT_SEGMENT_LIMIT_RESET = 13'h0000;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // relock time in ns, and its longest count at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int RELOCK_TIME_NS = 50000;
  localparam int RELOCK_CYCLES = RELOCK_TIME_NS / CLK_PERIOD_NS;
  // clock source selection
  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'b01,
    SRC_FAST_RC = 2'b10
  } clock_source_t;
  // pll lock tracking
  typedef enum logic [2:0] {
    PLL_LOCKED = 3'b001,
    PLL_RELOCKING = 3'b010,
    PLL_OFF = 3'b100
  } pll_state_t;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ### dv/trap_unit_chk.sv
// concurrent checks on the trap unit ports
`timescale 1ns/1ps
`default_nettype none
module trap_unit_chk #(
  parameter int RELOCK_COUNT = 20
) (
  // clock, reset and register port
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // traps, vectors and clocks
  input wire logic DMA_ERROR,
  input wire logic ALT_TABLE,
  input wire logic [23:0] DMA_VECTOR_ADDR,
  input wire logic SOFT_TRAP,
  input wire logic PLL_LOCK_LOST,
  input wire logic PRIMARY_OSC_OK,
  input wire logic PLL_LOCKED_OUT,
  input wire logic PLL_RUN,
  input wire logic USE_FAST_RC
);
  logic [12:0] bsl_reg;
  logic dma_reg;
  logic sel_reg;
  int unlock_cnt;
  wire logic clr3 = WR && ADDR == trap_flag_vector_pkg::ADDR_INTERRUPT_CONTROL_THREE && !WDATA[0];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // software-visible copies of the few registers the checks depend on
  always_ff @(posedge CLK)
    if (!RSTN) bsl_reg <= 13'h0000;
    else if (WR && ADDR == trap_flag_vector_pkg::ADDR_BOOT_SEGMENT_LIMIT) bsl_reg <= WDATA[12:0];
  always_ff @(posedge CLK)
    if (!RSTN) sel_reg <= 1'b0;
    else if (WR && ADDR == trap_flag_vector_pkg::ADDR_CLOCK_CONTROL) sel_reg <= WDATA[0];
  always_ff @(posedge CLK)
    if (!RSTN) dma_reg <= 1'b0;
    else if (DMA_ERROR) dma_reg <= 1'b1;
    else if (WR && ADDR == 4'h0 && !WDATA[5]) dma_reg <= 1'b0;
  // cycles spent unlocked since the lock-lost pin last dropped
  always_ff @(posedge CLK)
    if (!RSTN || PLL_LOCKED_OUT || PLL_LOCK_LOST) unlock_cnt <= 0;
    else unlock_cnt <= unlock_cnt + 1;
  sequence clear_trap_s;
    clr3 ##0 SOFT_TRAP;
  endsequence
  sequence trap_held_s;
    !clr3 ##1 SOFT_TRAP;
  endsequence
  AST_PRIMARY_VEC: assert property (!ALT_TABLE |=> DMA_VECTOR_ADDR == 24'h00000e)
    else $error("primary table vector wrong");
  AST_ALT_VEC: assert property (ALT_TABLE && !WR |=> DMA_VECTOR_ADDR == {11'h000, $past(bsl_reg)} + 24'h00000e)
    else $error("alternate table vector wrong");
  AST_DMA_FLAG: assert property (RD && ADDR == 4'h0 && !DMA_ERROR |=> RDATA[5] == $past(dma_reg))
    else $error("dma trap flag reads wrong");
  AST_PLL_CLEAR: assert property (clear_trap_s |=> ##1 !SOFT_TRAP)
    else $error("soft trap not cleared by software");
  AST_RUN_IN_TRAP: assert property (SOFT_TRAP |-> PLL_RUN)
    else $error("pll stopped while trap pending");
  AST_TRAP_HOLD: assert property (trap_held_s |=> SOFT_TRAP)
    else $error("soft trap dropped without clear");
  AST_RELOCK: assert property (unlock_cnt <= RELOCK_COUNT + 8)
    else $error("pll did not relock in time");
  AST_FALLBACK: assert property ((!sel_reg && !PRIMARY_OSC_OK) [*7] |-> USE_FAST_RC)
    else $error("no fallback to fast rc");
endmodule
`default_nettype wire

// ### dv/core_model.sv
// core side model: raises dma faults and picks the vector table
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // from the bench
  input wire logic CLK,
  input wire logic fault_req,
  input wire logic alt_req,
  // towards the trap unit
  output logic DMA_ERROR,
  output logic ALT_TABLE
);
  initial
  begin
    DMA_ERROR = 1'b0;
    ALT_TABLE = 1'b0;
  end
  always @(posedge CLK)
  begin
    DMA_ERROR <= fault_req;
    ALT_TABLE <= alt_req;
  end
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the trap flag and vector unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK = 1'b0, RSTN = 1'b0, WR = 1'b0, RD = 1'b0, fault_req = 1'b0, alt_req = 1'b0;
  logic PLL_LOCK_LOST = 1'b0, PRIMARY_OSC_OK = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic [15:0] RDATA;
  logic [23:0] DMA_VECTOR_ADDR;
  logic DMA_ERROR, ALT_TABLE, SOFT_TRAP, PLL_LOCKED_OUT, PLL_RUN, USE_FAST_RC, IRQ;
  int error_cnt = 0;
  int checked = 0;
  core_model i_core (.CLK(CLK), .fault_req(fault_req), .alt_req(alt_req), .DMA_ERROR(DMA_ERROR), .ALT_TABLE(ALT_TABLE));
  trap_flag_vector_unit #(.RELOCK_COUNT(20)) i_dut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .DMA_ERROR(DMA_ERROR), .ALT_TABLE(ALT_TABLE), .DMA_VECTOR_ADDR(DMA_VECTOR_ADDR),
    .SOFT_TRAP(SOFT_TRAP), .PLL_LOCK_LOST(PLL_LOCK_LOST), .PRIMARY_OSC_OK(PRIMARY_OSC_OK),
    .PLL_LOCKED_OUT(PLL_LOCKED_OUT), .PLL_RUN(PLL_RUN), .USE_FAST_RC(USE_FAST_RC), .IRQ(IRQ));
  initial
  begin
    forever #5 CLK = ~CLK;
  end
  task automatic compare(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic compare_bit(input logic got, input logic exp);
    compare({23'h000000, got}, {23'h000000, exp});
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    compare({8'h00, RDATA}, {8'h00, exp});
  endtask
  // lock lost during power-up on fast rc, then relock and software clear
  task automatic pll_trap();
    @(posedge CLK);
    PLL_LOCK_LOST <= 1'b1;
    repeat (3) @(posedge CLK);
    PLL_LOCK_LOST <= 1'b0;
    wait_clk(8);
    compare_bit(SOFT_TRAP, 1'b1);
    compare_bit(PLL_RUN, 1'b1);
    reg_rd(4'h1, 16'h0001);
    for (int i = 0; i < 60 && PLL_LOCKED_OUT !== 1'b1; i++) wait_clk(1);
    compare_bit(PLL_LOCKED_OUT, 1'b1);
    reg_wr(4'h1, 16'h0001);
    wait_clk(3);
    compare_bit(SOFT_TRAP, 1'b1);
    reg_wr(4'h1, 16'h0000);
    wait_clk(3);
    compare_bit(SOFT_TRAP, 1'b0);
    PLL_LOCK_LOST <= 1'b1;
    wait_clk(6);
    compare_bit(PLL_LOCKED_OUT, 1'b0);
    PLL_LOCK_LOST <= 1'b0;
    wait_clk(24);
    compare_bit(PLL_LOCKED_OUT, 1'b1);
    compare_bit(SOFT_TRAP, 1'b0);
  endtask
  // both tables, with a limit that carries past bit 12
  task automatic vectors();
    compare(DMA_VECTOR_ADDR, 24'h00000e);
    reg_wr(4'h3, 16'hfabc);
    alt_req <= 1'b1;
    wait_clk(4);
    compare(DMA_VECTOR_ADDR, 24'h001aca);
    reg_wr(4'h3, 16'h1ff2);
    wait_clk(4);
    compare(DMA_VECTOR_ADDR, 24'h002000);
    @(posedge CLK);
    alt_req <= 1'b0;
    wait_clk(4);
    compare(DMA_VECTOR_ADDR, 24'h00000e);
  endtask
  // dma fault: flag, sticky behaviour, masked interrupt and its clear
  task automatic dma_trap();
    reg_rd(4'h0, 16'h0000);
    reg_rd(4'h5, 16'h0000);
    reg_rd(4'hf, 16'h0000);
    reg_wr(4'h5, 16'h0001);
    wait_clk(2);
    compare_bit(IRQ, 1'b0);
    fault_req <= 1'b1;
    @(posedge CLK);
    fault_req <= 1'b0;
    wait_clk(4);
    compare_bit(IRQ, 1'b1);
    reg_rd(4'h0, 16'h0020);
    reg_wr(4'h0, 16'h0020);
    reg_rd(4'h0, 16'h0020);
    reg_wr(4'h0, 16'h0000);
    reg_rd(4'h0, 16'h0000);
    reg_wr(4'h4, 16'h0001);
    wait_clk(2);
    compare_bit(IRQ, 1'b0);
  endtask
  // primary comes up, then fails with rc select at 0
  task automatic fallback();
    compare_bit(USE_FAST_RC, 1'b1);
    PRIMARY_OSC_OK <= 1'b1;
    wait_clk(8);
    compare_bit(USE_FAST_RC, 1'b0);
    PRIMARY_OSC_OK <= 1'b0;
    wait_clk(8);
    compare_bit(USE_FAST_RC, 1'b1);
    reg_rd(4'h4, 16'h0006);
    reg_wr(4'h2, 16'h0001);
    reg_rd(4'h2, 16'h0001);
    PRIMARY_OSC_OK <= 1'b1;
    wait_clk(8);
    compare_bit(USE_FAST_RC, 1'b0);
    PRIMARY_OSC_OK <= 1'b0;
    wait_clk(8);
    compare_bit(USE_FAST_RC, 1'b0);
  endtask
  task automatic complete_run();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    pll_trap();
    vectors();
    dma_trap();
    fallback();
    complete_run();
  end
  initial
  begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule
bind trap_flag_vector_unit trap_unit_chk #(.RELOCK_COUNT(RELOCK_COUNT)) i_chk (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DMA_ERROR(DMA_ERROR), .ALT_TABLE(ALT_TABLE),
  .DMA_VECTOR_ADDR(DMA_VECTOR_ADDR), .SOFT_TRAP(SOFT_TRAP), .PLL_LOCK_LOST(PLL_LOCK_LOST),
  .PRIMARY_OSC_OK(PRIMARY_OSC_OK), .PLL_LOCKED_OUT(PLL_LOCKED_OUT), .PLL_RUN(PLL_RUN), .USE_FAST_RC(USE_FAST_RC));
`default_nettype wire
